// ### include/apf_pkg.sv
`default_nettype none
package apf_pkg;
	// Exception kinds in the order they are taken, highest first.
	typedef enum logic [2:0] {
		APF_EXC_NONE = 3'h0,
		APF_EXC_RESET = 3'h1,
		APF_EXC_DABT = 3'h2,
		APF_EXC_FAST = 3'h3,
		APF_EXC_IRQ = 3'h4,
		APF_EXC_PABT = 3'h5,
		APF_EXC_UNDEF_TRAP = 3'h6
	} apf_exc_t;
	// Extended fault status codes, bit 4 lands in status bit 10.
	localparam logic [4:0] APF_FS_ALIGN = 5'h01;
	localparam logic [4:0] APF_FS_EXT_L1 = 5'h0C;
	localparam logic [4:0] APF_FS_EXT_L2 = 5'h0E;
	localparam logic [4:0] APF_FS_TRANS_SEC = 5'h05;
	localparam logic [4:0] APF_FS_TRANS_PAGE = 5'h07;
	localparam logic [4:0] APF_FS_DOM_SEC = 5'h09;
	localparam logic [4:0] APF_FS_DOM_PAGE = 5'h0B;
	localparam logic [4:0] APF_FS_PERM_SEC = 5'h0D;
	localparam logic [4:0] APF_FS_PERM_PAGE = 5'h0F;
	localparam logic [4:0] APF_FS_IMMU = 5'h10;
	localparam logic [4:0] APF_FS_LOCK = 5'h14;
	localparam logic [4:0] APF_FS_EXT_BUS = 5'h16;
	localparam logic [4:0] APF_FS_PARITY = 5'h18;
	// Field positions of the extended code bit and the domain in the status register.
	localparam int APF_FSR_HI_BIT = 10;
	localparam int APF_FSR_DOM_LSB = 4;
	// Link offsets.
	localparam logic [31:0] APF_LINK_OFF4 = 32'h0000_0004;
	localparam logic [31:0] APF_LINK_OFF8 = 32'h0000_0008;
	// Longest delay, in instructions, of a stall-until-complete abort.
	localparam int APF_STALL_MAX_INSTR = 3;
	localparam logic [31:0] APF_RESET_WORD = 32'h0000_0000;
endpackage : apf_pkg
`default_nettype wire

// ### include/apf_fault_if.sv
`default_nettype none
// Resolved abort carried from the classifier to the top.
interface apf_fault_if;
	import apf_pkg::*;
	logic valid;
	logic [4:0] code;
	logic dom_valid;
	logic far_valid;
	logic precise;
	modport src (output valid, output code, output dom_valid, output far_valid, output precise);
	modport dst (input valid, input code, input dom_valid, input far_valid, input precise);
endinterface : apf_fault_if
`default_nettype wire

// ### hw/apf_dabt_class.sv
`default_nettype none
// Ranks data abort causes and encodes the winner.
module apf_dabt_class
	import apf_pkg::*;
(
	input wire logic align_i,
	input wire logic ext_l1_i,
	input wire logic ext_l2_i,
	input wire logic trans_i,
	input wire logic dom_i,
	input wire logic perm_i,
	input wire logic is_page_i,
	input wire logic is_preload_i,
	input wire logic lock_i,
	input wire logic bus_err_i,
	input wire logic parity_i,
	apf_fault_if.src flt
);
	logic mmu_hit;

	// Preload hints drop translation, domain and permission faults silently.
	assign mmu_hit = (trans_i | dom_i | perm_i) & ~is_preload_i;

	// Fixed ranking; only the top cause is reported, others recur on retry.
	always_comb begin
		flt.valid = 1'b1;
		flt.precise = 1'b1;
		flt.dom_valid = 1'b0;
		flt.far_valid = 1'b1;
		flt.code = APF_FS_ALIGN;
		if (align_i) begin
			flt.code = APF_FS_ALIGN;
		end else if (ext_l1_i | ext_l2_i) begin
			flt.code = ext_l1_i ? APF_FS_EXT_L1 : APF_FS_EXT_L2;
			flt.dom_valid = ~ext_l1_i;
		end else if (mmu_hit & trans_i) begin
			flt.code = is_page_i ? APF_FS_TRANS_PAGE : APF_FS_TRANS_SEC;
			flt.dom_valid = is_page_i;
		end else if (mmu_hit & dom_i) begin
			flt.code = is_page_i ? APF_FS_DOM_PAGE : APF_FS_DOM_SEC;
			flt.dom_valid = 1'b1;
		end else if (mmu_hit & perm_i) begin
			flt.code = is_page_i ? APF_FS_PERM_PAGE : APF_FS_PERM_SEC;
			flt.dom_valid = 1'b1;
		end else if (lock_i) begin
			flt.code = APF_FS_LOCK;
			flt.far_valid = 1'b0;
		end else if (bus_err_i) begin
			flt.code = APF_FS_EXT_BUS;
			flt.far_valid = 1'b0;
			flt.precise = 1'b0;
		end else if (parity_i) begin
			flt.code = APF_FS_PARITY;
			flt.far_valid = 1'b0;
			flt.precise = 1'b0;
		end else begin
			flt.valid = 1'b0;
			flt.far_valid = 1'b0;
		end
	end
endmodule : apf_dabt_class
`default_nettype wire

// ### hw/apf_pabt_class.sv
`default_nettype none
// Ranks prefetch abort causes; domain and address never valid.
module apf_pabt_class
	import apf_pkg::*;
(
	input wire logic immu_i,
	input wire logic ibus_err_i,
	input wire logic iparity_i,
	apf_fault_if.src flt
);
	// Highest cause wins the status field.
	always_comb begin
		flt.valid = immu_i | ibus_err_i | iparity_i;
		flt.precise = 1'b1;
		flt.dom_valid = 1'b0;
		flt.far_valid = 1'b0;
		if (immu_i) begin
			flt.code = APF_FS_IMMU;
		end else if (ibus_err_i) begin
			flt.code = APF_FS_EXT_BUS;
		end else begin
			flt.code = APF_FS_PARITY;
		end
	end
endmodule : apf_pabt_class
`default_nettype wire

// ### hw/apf_abort_unit.sv
`default_nettype none
module apf_abort_unit
	import apf_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int STALL_MAX = APF_STALL_MAX_INSTR
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_req_i,
	input wire logic fast_interrupt_i,
	input wire logic irq_i,
	input wire logic undef_i,
	input wire logic software_trap_i,
	input wire logic immu_fault_i,
	input wire logic ibus_err_i,
	input wire logic iparity_i,
	input wire logic [ADDR_W-1:0] fetch_pc_i,
	input wire logic align_fault_i,
	input wire logic ext_l1_i,
	input wire logic ext_l2_i,
	input wire logic trans_fault_i,
	input wire logic domain_fault_i,
	input wire logic perm_fault_i,
	input wire logic is_page_i,
	input wire logic [3:0] domain_i,
	input wire logic preload_hint_i,
	input wire logic lock_fault_i,
	input wire logic dbus_err_i,
	input wire logic dparity_i,
	input wire logic stall_access_i,
	input wire logic instr_retire_i,
	input wire logic [ADDR_W-1:0] exec_pc_i,
	input wire logic [ADDR_W-1:0] next_pc_i,
	input wire logic [ADDR_W-1:0] data_addr_i,
	output logic preload_issue_o,
	output logic [2:0] exc_take_o,
	output logic exc_valid_o,
	output logic restore_base_o,
	output logic [31:0] fault_status_reg_o,
	output logic [ADDR_W-1:0] fault_address_reg_o,
	output logic [ADDR_W-1:0] abort_link_reg_o,
	output logic stall_late_o
);
	apf_fault_if d_flt ();
	apf_fault_if p_flt ();
	apf_exc_t take;
	logic dabt_pend, imprecise_pend;
	logic [31:0] fault_status_reg, fault_status_next;
	logic [ADDR_W-1:0] fault_address_reg, fault_address_next;
	logic [ADDR_W-1:0] abort_link_reg, abort_link_next;
	logic [2:0] exc_reg;
	logic exc_valid_reg, restore_base_reg, stall_late_reg;
	logic stall_track_reg;
	logic [3:0] stall_cnt_reg;
	logic preload_mmu;

	// Splits a 5-bit extended code into bit 10 and bits 3:0 of the status word.
	function automatic logic [31:0] pack_status(input logic [4:0] code, input logic [3:0] dom);
		logic [31:0] w;
		w = APF_RESET_WORD;
		w[APF_FSR_HI_BIT] = code[4];
		w[3:0] = code[3:0];
		w[APF_FSR_DOM_LSB+3:APF_FSR_DOM_LSB] = dom;
		return w;
	endfunction

	apf_dabt_class u_dabt (
		.align_i(align_fault_i),
		.ext_l1_i(ext_l1_i),
		.ext_l2_i(ext_l2_i),
		.trans_i(trans_fault_i),
		.dom_i(domain_fault_i),
		.perm_i(perm_fault_i),
		.is_page_i(is_page_i),
		.is_preload_i(preload_hint_i),
		.lock_i(lock_fault_i),
		.bus_err_i(dbus_err_i),
		.parity_i(dparity_i),
		.flt(d_flt)
	);

	apf_pabt_class u_pabt (
		.immu_i(immu_fault_i),
		.ibus_err_i(ibus_err_i),
		.iparity_i(iparity_i),
		.flt(p_flt)
	);

	// A preload hint with a translation, domain, permission or alignment fault issues no memory load.
	assign preload_mmu = trans_fault_i | domain_fault_i | perm_fault_i;
	assign preload_issue_o = preload_hint_i & ~preload_mmu & ~align_fault_i;

	assign dabt_pend = d_flt.valid;
	assign imprecise_pend = d_flt.valid & ~d_flt.precise;

	// Fixed exception priority.
	always_comb begin
		if (reset_req_i) begin
			take = APF_EXC_RESET;
		end else if (dabt_pend) begin
			take = APF_EXC_DABT;
		end else if (fast_interrupt_i) begin
			take = APF_EXC_FAST;
		end else if (irq_i) begin
			take = APF_EXC_IRQ;
		end else if (p_flt.valid) begin
			take = APF_EXC_PABT;
		end else if (undef_i | software_trap_i) begin
			take = APF_EXC_UNDEF_TRAP;
		end else begin
			take = APF_EXC_NONE;
		end
	end

	// Next values of the status, address and link registers.
	always_comb begin
		fault_status_next = fault_status_reg;
		fault_address_next = fault_address_reg;
		abort_link_next = abort_link_reg;
		case (take)
			APF_EXC_DABT: begin
				// Only listed codes reach here, so reserved codes never appear.
				fault_status_next = pack_status(d_flt.code, d_flt.dom_valid ? domain_i : 4'h0);
				if (d_flt.far_valid) begin
					fault_address_next = data_addr_i;
				end
				if (d_flt.precise) begin
					abort_link_next = ADDR_W'(exec_pc_i + APF_LINK_OFF8);
				end else begin
					abort_link_next = ADDR_W'(next_pc_i + APF_LINK_OFF4);
				end
			end
			APF_EXC_PABT: begin
				fault_status_next = pack_status(p_flt.code, 4'h0);
				abort_link_next = ADDR_W'(fetch_pc_i + APF_LINK_OFF4);
			end
			default: begin
				fault_status_next = fault_status_reg;
			end
		endcase
	end

	// Fault registers load only on abort entry and hold otherwise.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fault_status_reg <= APF_RESET_WORD;
			fault_address_reg <= '0;
			abort_link_reg <= '0;
		end else begin
			fault_status_reg <= fault_status_next;
			fault_address_reg <= fault_address_next;
			abort_link_reg <= abort_link_next;
		end
	end

	// Taken exception and base restore decision, registered one cycle after the decision.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			exc_reg <= 3'h0;
			exc_valid_reg <= 1'b0;
			restore_base_reg <= 1'b0;
		end else begin
			exc_reg <= take;
			exc_valid_reg <= (take != APF_EXC_NONE);
			restore_base_reg <= (take == APF_EXC_DABT) & d_flt.precise;
		end
	end

	// Tracks a stall-until-complete access; its bus error must arrive in time.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stall_track_reg <= 1'b0;
			stall_cnt_reg <= 4'h0;
			stall_late_reg <= 1'b0;
		end else begin
			stall_late_reg <= 1'b0;
			if (imprecise_pend | (stall_track_reg & (stall_cnt_reg == 4'(STALL_MAX)))) begin
				stall_track_reg <= 1'b0;
				stall_cnt_reg <= 4'h0;
			end else if (stall_access_i) begin
				stall_track_reg <= 1'b1;
				stall_cnt_reg <= 4'h0;
			end else if (stall_track_reg & instr_retire_i) begin
				stall_cnt_reg <= 4'(stall_cnt_reg + 4'h1);
			end
			// Flags a pending stalled access that outran its window.
			if (stall_track_reg & (stall_cnt_reg == 4'(STALL_MAX)) & dbus_err_i) begin
				stall_late_reg <= 1'b1;
			end
		end
	end

	// Registered outputs; the late flag marks a bus error at the very end of the stall window.
	assign stall_late_o = stall_late_reg;
	assign exc_take_o = exc_reg;
	assign exc_valid_o = exc_valid_reg;
	assign restore_base_o = restore_base_reg;
	assign fault_status_reg_o = fault_status_reg;
	assign fault_address_reg_o = fault_address_reg;
	assign abort_link_reg_o = abort_link_reg;
endmodule : apf_abort_unit
`default_nettype wire

// ### tb/apf_abort_chk.sv
`default_nettype none
// Watches the abort unit ports for ordering, link, status and hold behaviour.
module apf_abort_chk
	import apf_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_req_i,
	input wire logic [ADDR_W-1:0] fetch_pc_i,
	input wire logic [ADDR_W-1:0] exec_pc_i,
	input wire logic [ADDR_W-1:0] next_pc_i,
	input wire logic align_fault_i,
	input wire logic ext_l1_i,
	input wire logic ext_l2_i,
	input wire logic trans_fault_i,
	input wire logic domain_fault_i,
	input wire logic perm_fault_i,
	input wire logic preload_hint_i,
	input wire logic lock_fault_i,
	input wire logic dbus_err_i,
	input wire logic preload_issue_o,
	input wire logic [2:0] exc_take_o,
	input wire logic exc_valid_o,
	input wire logic restore_base_o,
	input wire logic [31:0] fault_status_reg_o,
	input wire logic [ADDR_W-1:0] fault_address_reg_o,
	input wire logic [ADDR_W-1:0] abort_link_reg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic pre_d;
	logic [4:0] code;
	// Any data cause that outranks an imprecise bus error.
	assign pre_d = align_fault_i | ext_l1_i | ext_l2_i | trans_fault_i | domain_fault_i | perm_fault_i | lock_fault_i;
	assign code = {fault_status_reg_o[10], fault_status_reg_o[3:0]};
	// A lone data bus error with no reset pending.
	sequence s_bus_only;
		dbus_err_i && !reset_req_i && !pre_d;
	endsequence
	chk_reset_first: assert property (reset_req_i |=> exc_take_o == 3'h1)
		else $error("reset request not taken first");
	chk_bus_imprecise: assert property (s_bus_only |=> exc_take_o == 3'h2 && !restore_base_o)
		else $error("data bus error not taken as imprecise abort");
	chk_impr_link: assert property (s_bus_only |=> abort_link_reg_o == $past(next_pc_i) + 32'h4)
		else $error("imprecise abort link wrong");
	chk_pabt_link: assert property (exc_take_o == 3'h5 |-> abort_link_reg_o == $past(fetch_pc_i) + 32'h4)
		else $error("prefetch abort link wrong");
	chk_prec_link: assert property (restore_base_o |-> abort_link_reg_o == $past(exec_pc_i) + 32'h8)
		else $error("precise abort link wrong");
	chk_regs_hold: assert property (!exc_valid_o |-> $stable(fault_status_reg_o) && $stable(fault_address_reg_o))
		else $error("fault registers changed without abort entry");
	chk_preload_drop: assert property (preload_hint_i && (trans_fault_i || domain_fault_i || perm_fault_i) |-> !preload_issue_o)
		else $error("faulting preload issued a load");
	chk_dcode_legal: assert property (exc_take_o == 3'h2 |-> code inside {5'h01, 5'h0C, 5'h0E, 5'h05, 5'h07,
		5'h09, 5'h0B, 5'h0D, 5'h0F, 5'h14, 5'h16, 5'h18})
		else $error("reserved data abort code");
	chk_pcode_legal: assert property (exc_take_o == 3'h5 |-> code inside {5'h10, 5'h16, 5'h18})
		else $error("reserved prefetch abort code");
endmodule // apf_abort_chk
bind apf_abort_unit apf_abort_chk #(.ADDR_W(ADDR_W)) i_chk (.clk_i, .rst_i, .reset_req_i, .fetch_pc_i, .exec_pc_i,
	.next_pc_i, .align_fault_i, .ext_l1_i, .ext_l2_i, .trans_fault_i, .domain_fault_i, .perm_fault_i, .preload_hint_i,
	.lock_fault_i, .dbus_err_i, .preload_issue_o, .exc_take_o, .exc_valid_o, .restore_base_o, .fault_status_reg_o,
	.fault_address_reg_o, .abort_link_reg_o);
`default_nettype wire

// ### tb/apf_pipe_model.sv
`default_nettype none
// Pipeline stand-in: retires one instruction each cycle while running.
module apf_pipe_model (
	input wire logic clk_i,
	input wire logic run_i,
	output logic instr_retire_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Changes land on the falling edge, away from the sampling edge.
	always @(negedge clk_i) begin
		instr_retire_o <= run_i;
	end
endmodule // apf_pipe_model
`default_nettype wire

// ### tb/tb_abort_priority_fault_status.sv
`default_nettype none
module tb_abort_priority_fault_status;
	timeunit 1ns;
	timeprecision 1ps;
	import apf_pkg::*;
	logic clk_i, rst_i, reset_req_i, fast_interrupt_i, irq_i, undef_i, software_trap_i, immu_fault_i, ibus_err_i;
	logic iparity_i, align_fault_i, ext_l1_i, ext_l2_i, trans_fault_i, domain_fault_i, perm_fault_i, is_page_i;
	logic preload_hint_i, lock_fault_i, dbus_err_i, dparity_i, stall_access_i, instr_retire_i, run;
	logic preload_issue_o, exc_valid_o, restore_base_o, stall_late_o;
	logic [2:0] exc_take_o;
	logic [3:0] domain_i;
	logic [31:0] fetch_pc_i, exec_pc_i, next_pc_i, data_addr_i, fault_status_reg_o, fault_address_reg_o, abort_link_reg_o;
	int miscompares = 0;
	int num_checks = 0;
	logic [4:0] dcode [18] = '{5'h01, 5'h01, 5'h0C, 5'h0C, 5'h0E, 5'h0E, 5'h05, 5'h07, 5'h09, 5'h0B, 5'h0D, 5'h0F,
		5'h14, 5'h14, 5'h16, 5'h16, 5'h18, 5'h18};
	logic [4:0] pcode [3] = '{5'h10, 5'h16, 5'h18};
	apf_abort_unit i_dut (.*);
	apf_pipe_model i_pipe (.clk_i(clk_i), .run_i(run), .instr_retire_o(instr_retire_i));
	// Free-running 125 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic clr;
		{reset_req_i, fast_interrupt_i, irq_i, undef_i, software_trap_i, immu_fault_i, ibus_err_i, iparity_i} = '0;
		{align_fault_i, ext_l1_i, ext_l2_i, trans_fault_i, domain_fault_i, perm_fault_i, is_page_i} = '0;
		{preload_hint_i, lock_fault_i, dbus_err_i, dparity_i, stall_access_i} = '0;
		domain_i = 4'h0;
	endtask
	// One sampling edge, then back to the falling edge where outputs have settled.
	task automatic step;
		@(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic t_prio;
		for (int i = 0; i < 6; i++) begin
			clr();
			{reset_req_i, dbus_err_i, fast_interrupt_i, irq_i, immu_fault_i, undef_i} = 6'h3F >> i;
			step();
			chk(exc_take_o, i + 1);
			chk(exc_valid_o, 1);
		end
		clr();
		software_trap_i = 1'b1;
		step();
		chk(exc_take_o, 6);
		$display("t_prio done");
	endtask
	task automatic t_dabt;
		for (int n = 0; n < 18; n++) begin
			clr();
			is_page_i = n[0];
			domain_i = 4'h5;
			data_addr_i = 32'h0000_2000 + n * 4;
			exec_pc_i = 32'h0000_3000 + n * 4;
			next_pc_i = 32'h0000_4000 + n * 4;
			{align_fault_i, ext_l1_i, ext_l2_i, trans_fault_i, domain_fault_i, perm_fault_i, lock_fault_i, dbus_err_i,
				dparity_i} = 9'h1FF >> (n / 2);
			step();
			chk(exc_take_o, 2);
			chk({fault_status_reg_o[10], fault_status_reg_o[3:0]}, dcode[n]);
			if (n < 12) chk(fault_address_reg_o, data_addr_i);
			chk(fault_status_reg_o[7:4], (n / 2 == 2 || n == 7 || n / 2 == 4 || n / 2 == 5) ? 4'h5 : 4'h0);
			chk(abort_link_reg_o, n < 14 ? exec_pc_i + 8 : next_pc_i + 4);
			chk(restore_base_o, n < 14);
		end
		clr();
		align_fault_i = 1'b1;
		data_addr_i = 32'h0000_5000;
		step();
		clr();
		dparity_i = 1'b1;
		data_addr_i = 32'h0000_6000;
		step();
		chk(fault_address_reg_o, 32'h0000_5000);
		$display("t_dabt done");
	endtask
	task automatic t_preload;
		clr();
		preload_hint_i = 1'b1;
		#1;
		chk(preload_issue_o, 1);
		@(negedge clk_i);
		for (int k = 0; k < 3; k++) begin
			{trans_fault_i, domain_fault_i, perm_fault_i} = 3'h4 >> k;
			#1;
			chk(preload_issue_o, 0);
			step();
			chk(exc_take_o, 0);
			chk(exc_valid_o, 0);
			chk({fault_status_reg_o[10], fault_status_reg_o[3:0]}, 5'h18);
		end
		$display("t_preload done");
	endtask
	task automatic t_pabt;
		for (int i = 0; i < 3; i++) begin
			clr();
			fetch_pc_i = 32'h0000_1000 + i * 16;
			{immu_fault_i, ibus_err_i, iparity_i} = 3'h7 >> i;
			step();
			chk({fault_status_reg_o[10], fault_status_reg_o[3:0]}, pcode[i]);
			chk(abort_link_reg_o, fetch_pc_i + 4);
			chk(fault_address_reg_o, 32'h0000_5000);
		end
		$display("t_pabt done");
	endtask
	task automatic t_stall;
		clr();
		stall_access_i = 1'b1;
		run = 1'b1;
		step();
		stall_access_i = 1'b0;
		step();
		dbus_err_i = 1'b1;
		next_pc_i = 32'h0000_7000;
		step();
		chk(exc_take_o, 2);
		chk(abort_link_reg_o, 32'h0000_7004);
		chk(stall_late_o, 0);
		// Second stalled access: its bus error only comes after three retired instructions.
		clr();
		stall_access_i = 1'b1;
		step();
		stall_access_i = 1'b0;
		repeat (3) step();
		dbus_err_i = 1'b1;
		step();
		run = 1'b0;
		chk(stall_late_o, 1);
		$display("t_stall done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Cuts a hang short well past the under one hundred cycles the tests need.
	initial begin
		#100000;
		miscompares++;
		finish_test();
	end
	initial begin
		clr();
		run = 1'b0;
		rst_i = 1'b1;
		{fetch_pc_i, exec_pc_i, next_pc_i, data_addr_i} = '0;
		repeat (12) @(negedge clk_i);
		rst_i = 1'b0;
		chk(fault_status_reg_o, 32'h0000_0000);
		t_prio();
		t_dabt();
		t_preload();
		t_pabt();
		t_stall();
		finish_test();
	end
endmodule // tb_abort_priority_fault_status
`default_nettype wire
